/* hxb_params.svh */
// Constants for the host to expansion bus bridge control block.
// Assumes inclusion by bare name from the bridge design file.
`ifndef HXB_PARAMS_SVH
`define HXB_PARAMS_SVH

// Core clock rate and I/O recovery time
`define HXB_CLK_MHZ 20
`define HXB_IO_REC_NS 1000
`define HXB_IO_REC_CYC (((`HXB_IO_REC_NS) * (`HXB_CLK_MHZ) + 999) / 1000)
`define HXB_REC_W 8

// Cycles from decode state entry to claim sample point
`define HXB_DECODE_CYC 2'h2

// Divider select codes and ratios
`define HXB_SEL_DIV3 3'h0
`define HXB_SEL_DIV4 3'h1
`define HXB_SEL_DIV5 3'h2
`define HXB_SEL_DIV6 3'h3
`define HXB_SEL_DIV8 3'h4
`define HXB_DIV3 4'h3
`define HXB_DIV4 4'h4
`define HXB_DIV5 4'h5
`define HXB_DIV6 4'h6
`define HXB_DIV8 4'h8

// Slot decode
`define HXB_SLOTS 6
`define HXB_SLOT_LOW_MASK 2'h0

// Width of synchronised pin vector
`define HXB_SYNC_W 45

`endif

/* hxb_pkg.sv */
// Types for the host to expansion bus bridge control block.
// Assumes hxb_params.svh is available for constants.
package hxb_pkg;

    // Host-initiated cycle tracking
    typedef enum logic [2:0] {
        HS_IDLE,
        HS_DECODE,
        HS_LOCAL,
        HS_PEND,
        HS_START,
        HS_WAIT,
        HS_READY
    } hxb_host_state_t;

endpackage

/* hxb_bridge.sv */
// Host side control of the host to expansion bus bridge.
// Assumes one core clock; expansion side signals arrive as pins.
//
// Behaviour
// - Unclaimed host master cycles are forwarded to the expansion bus.
// - Expansion master cycles are passed on to the host bus once hold is granted.
// - A recovery delay separates consecutive forwarded I/O cycles.
// - Expansion bus clock is divided down from the host CPU clock.
// - Divider supports ratios 3, 4, 5, 6 and 8.
// - Address strobes track host cycles; unanswered ones run expansion cycles.
// - Byte lanes are inputs for host masters, driven otherwise.
// - Upper byte flag sampled on forwarded cycles, driven for master/DMA.
// - Next-address pulses when the CPU reaches an expansion slave.
// - Data/control is input for host masters, driven high otherwise.
// - Write/read sampled on forwarded cycles, driven for masters.
// - Memory/I/O is input for host masters, driven high for DMA.
// - Host ready output asserts when expansion readies complete the cycle.
// - Early ready asserts one cycle before host ready output.
// - Local memory claim blocks forwarding and marks host memory target.
// - Local I/O claim blocks forwarding and marks host I/O target.
// - Stall input keeps expansion clock low during command phase.
// - Host hold request follows the peripheral hold request.
// - Expansion lock asserts for locked host cycles to expansion targets.
// - Snoop strobe pulses on DMA I/O to memory, master memory writes and CPU writes to host memory.
// - Slot enables decode from global enable, upper address nibble and low two address bits.
`timescale 1ns/100ps
`include "hxb_params.svh"

module hxb_bridge (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Host cycle definition pins
    input wire logic [1:0] hostAddressStrobes,
    input wire logic [3:0] hostByteLanesNIn,
    output logic [3:0] hostByteLanesNOut,
    output logic hostByteLanesOe,
    input wire logic hostUpperByteFlagNIn,
    output logic hostUpperByteFlagNOut,
    output logic hostUpperByteFlagOe,
    input wire logic hostDataControlSelIn,
    output logic hostDataControlSelOut,
    output logic hostDataControlSelOe,
    input wire logic hostWriteReadSelIn,
    output logic hostWriteReadSelOut,
    output logic hostWriteReadSelOe,
    input wire logic hostMemIoSelIn,
    output logic hostMemIoSelOut,
    output logic hostMemIoSelOe,
    // Host ready, claims and lock
    input wire logic hostReadyInN,
    output logic hostReadyOutN,
    output logic hostEarlyReadyOutN,
    output logic hostPipelineAddrOkN,
    input wire logic hostLocalMemoryClaimN,
    input wire logic hostLocalIoClaimN,
    input wire logic hostClockStallN,
    input wire logic hostLockInN,
    output logic hostSnoopStrobeN,
    // Bus hand-over
    output logic hostHoldRequest,
    input wire logic hostHoldGrant,
    input wire logic peripheralHoldRequest,
    input wire logic peripheralReady,
    input wire logic peripheralTarget,
    // Expansion bus status
    input wire logic expReady,
    input wire logic chanReady,
    input wire logic noWaitN,
    input wire logic expMasterCycle,
    input wire logic dmaCycle,
    input wire logic dmaIoToMem,
    input wire logic expCommand,
    input wire logic expMasterWrite,
    input wire logic expMasterMem,
    input wire logic [3:0] expByteLanesN,
    input wire logic expUpperByteN,
    input wire logic [2:0] clkRatioSel,
    // Expansion cycle requests
    output logic expCycleStart,
    output logic expCycleWrite,
    output logic expCycleMem,
    output logic [3:0] expCycleByteLanesN,
    output logic expCycleUpperByteN,
    output logic expCycleIntAck,
    output logic expCycleShutdown,
    output logic expLockN,
    output logic expBusClk,
    output logic hostCycleStart,
    output logic hostTargetMem,
    output logic hostTargetIo,
    // Slot enables
    input wire logic globalSlotEnableN,
    input wire logic [7:0] slotAddrHigh,
    output logic [`HXB_SLOTS-1:0] slotEnableN
);

    //--------------------------------------------------------------
    // Pin synchronisers
    //--------------------------------------------------------------
    logic [`HXB_SYNC_W-1:0] rawIn;
    logic [`HXB_SYNC_W-1:0] meta_q;
    logic [`HXB_SYNC_W-1:0] sync_q;
    logic [1:0] ads;
    logic [3:0] hBl;
    logic hUpper, hDc, hWr, hMio, rdyInN, locMemN, locIoN, stallN;
    logic grant, pHold, pRdy, pTgt, lockN, gSlotN, exRdy, chRdy, nowsN;
    logic xMaster, dma, dmaIoMem, cmd, xWrite, xMem, xUpperN;
    logic [3:0] xBlN;
    logic [7:0] addrHi;
    logic [2:0] ratioSel;

    assign rawIn = {hostAddressStrobes, hostByteLanesNIn, hostUpperByteFlagNIn,
        hostDataControlSelIn, hostWriteReadSelIn, hostMemIoSelIn, hostReadyInN,
        hostLocalMemoryClaimN, hostLocalIoClaimN, hostClockStallN, hostHoldGrant,
        peripheralHoldRequest, peripheralReady, peripheralTarget, hostLockInN,
        globalSlotEnableN, expReady, chanReady, noWaitN, expMasterCycle, dmaCycle,
        dmaIoToMem, expCommand, expMasterWrite, expMasterMem, expByteLanesN,
        expUpperByteN, slotAddrHigh, clkRatioSel};

    assign {ads, hBl, hUpper, hDc, hWr, hMio, rdyInN, locMemN, locIoN, stallN,
        grant, pHold, pRdy, pTgt, lockN, gSlotN, exRdy, chRdy, nowsN, xMaster,
        dma, dmaIoMem, cmd, xWrite, xMem, xBlN, xUpperN, addrHi, ratioSel} = sync_q;

    // Two flops per pin, first flop read only by the second
    genvar i;
    for (i = 0; i < `HXB_SYNC_W; i++) begin : g_sync
        always_ff @(posedge core_clk) begin
            if (!resetn) begin
                meta_q[i] <= 1'b0;
                sync_q[i] <= 1'b0;
            end else begin
                meta_q[i] <= rawIn[i];
                sync_q[i] <= meta_q[i];
            end
        end
    end

    //--------------------------------------------------------------
    // Ownership and pin direction
    //--------------------------------------------------------------
    logic xOwn;
    logic anyOwn;
    logic dmaOwn;

    // Expansion side owns the host bus only after the grant
    assign xOwn = grant && xMaster;
    assign dmaOwn = grant && dma;
    assign anyOwn = xOwn || dmaOwn;

    // Byte lanes and upper byte flag driven for master and DMA
    assign hostByteLanesOe = anyOwn;
    assign hostByteLanesNOut = xBlN;
    assign hostUpperByteFlagOe = anyOwn;
    assign hostUpperByteFlagNOut = xUpperN;
    // Data/control high for master and DMA
    assign hostDataControlSelOe = anyOwn;
    assign hostDataControlSelOut = 1'b1;
    // Write/read driven for expansion masters only
    assign hostWriteReadSelOe = xOwn;
    assign hostWriteReadSelOut = xWrite;
    // Memory/I/O high during DMA only
    assign hostMemIoSelOe = dmaOwn;
    assign hostMemIoSelOut = 1'b1;

    //--------------------------------------------------------------
    // Host cycle tracking
    //--------------------------------------------------------------
    hxb_pkg::hxb_host_state_t state_q;
    logic [1:0] decCnt_q;
    logic [`HXB_REC_W-1:0] recCnt_q;
    logic claimed;
    logic expDone;
    logic decodeEnd;

    assign claimed = !locMemN || !locIoN;
    assign decodeEnd = (state_q == hxb_pkg::HS_DECODE) && (decCnt_q == `HXB_DECODE_CYC);
    // Completion from expansion readies or peripheral ready
    assign expDone = !nowsN || (pTgt ? pRdy : (exRdy && chRdy));

    // Cycle sequencer
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            state_q <= hxb_pkg::HS_IDLE;
        end else begin
            case (state_q)
                hxb_pkg::HS_IDLE: if (|ads && !grant) state_q <= hxb_pkg::HS_DECODE;
                hxb_pkg::HS_DECODE: if (decodeEnd) begin
                    state_q <= claimed ? hxb_pkg::HS_LOCAL : hxb_pkg::HS_PEND;
                end
                hxb_pkg::HS_LOCAL: if (!rdyInN) state_q <= hxb_pkg::HS_IDLE;
                hxb_pkg::HS_PEND: if (recCnt_q == '0) state_q <= hxb_pkg::HS_START;
                hxb_pkg::HS_START: state_q <= hxb_pkg::HS_WAIT;
                hxb_pkg::HS_WAIT: if (expDone) state_q <= hxb_pkg::HS_READY;
                hxb_pkg::HS_READY: state_q <= hxb_pkg::HS_IDLE;
                default: state_q <= hxb_pkg::HS_IDLE;
            endcase
        end
    end

    // Decode sample point counter
    always_ff @(posedge core_clk) begin
        decCnt_q <= (!resetn || state_q != hxb_pkg::HS_DECODE) ? 2'h0 : decCnt_q + 2'h1;
    end

    // I/O recovery after each forwarded I/O cycle
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            recCnt_q <= '0;
        end else if (state_q == hxb_pkg::HS_READY && !expCycleMem) begin
            recCnt_q <= `HXB_REC_W'(`HXB_IO_REC_CYC);
        end else if (recCnt_q != '0) begin
            recCnt_q <= recCnt_q - `HXB_REC_W'(1);
        end
    end

    // Cycle attributes captured at the decode point
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            expCycleWrite <= 1'b0;
            expCycleMem <= 1'b0;
            expCycleByteLanesN <= 4'hF;
            expCycleUpperByteN <= 1'b1;
            expCycleIntAck <= 1'b0;
            expCycleShutdown <= 1'b0;
        end else if (decodeEnd) begin
            expCycleWrite <= hWr;
            expCycleMem <= hMio;
            expCycleByteLanesN <= hBl;
            expCycleUpperByteN <= hUpper;
            expCycleIntAck <= !hMio && !hDc && !hWr;
            expCycleShutdown <= hMio && !hDc && hWr;
        end
    end

    // Start, next-address, ready and early ready strobes
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            expCycleStart <= 1'b0;
            hostPipelineAddrOkN <= 1'b1;
            hostEarlyReadyOutN <= 1'b1;
            hostReadyOutN <= 1'b1;
        end else begin
            expCycleStart <= state_q == hxb_pkg::HS_PEND && recCnt_q == '0;
            hostPipelineAddrOkN <= !(state_q == hxb_pkg::HS_START);
            hostEarlyReadyOutN <= !(state_q == hxb_pkg::HS_WAIT && expDone);
            hostReadyOutN <= hostEarlyReadyOutN;
        end
    end

    //--------------------------------------------------------------
    // Lock, hold, snoop and host targets
    //--------------------------------------------------------------
    logic cmd_q;
    logic cmdRise;
    logic snoopEvt;

    assign cmdRise = cmd && !cmd_q;
    // DMA I/O to memory, master memory writes, CPU writes to host memory
    assign snoopEvt = (cmdRise && dmaOwn && dmaIoMem)
        || (cmdRise && xOwn && xWrite && xMem)
        || (decodeEnd && !locMemN && hWr && hMio);

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            cmd_q <= 1'b0;
            expLockN <= 1'b1;
            hostHoldRequest <= 1'b0;
            hostSnoopStrobeN <= 1'b1;
            hostCycleStart <= 1'b0;
            hostTargetMem <= 1'b0;
            hostTargetIo <= 1'b0;
        end else begin
            cmd_q <= cmd;
            expLockN <= !(!lockN && (state_q == hxb_pkg::HS_START
                || state_q == hxb_pkg::HS_WAIT || state_q == hxb_pkg::HS_READY));
            hostHoldRequest <= pHold;
            hostSnoopStrobeN <= !snoopEvt;
            hostCycleStart <= cmdRise && xOwn;
            hostTargetMem <= anyOwn && !locMemN;
            hostTargetIo <= xOwn && !xMem && !locIoN;
        end
    end

    //--------------------------------------------------------------
    // Expansion bus clock divider
    //--------------------------------------------------------------
    logic [3:0] divCnt_q;
    logic [3:0] divRatio;
    logic lowPhase;
    logic stall;

    // Divider ratio from select pins
    always_comb begin
        case (ratioSel)
            `HXB_SEL_DIV3: divRatio = `HXB_DIV3;
            `HXB_SEL_DIV4: divRatio = `HXB_DIV4;
            `HXB_SEL_DIV5: divRatio = `HXB_DIV5;
            `HXB_SEL_DIV6: divRatio = `HXB_DIV6;
            default: divRatio = `HXB_DIV8;
        endcase
    end

    assign lowPhase = divCnt_q >= (divRatio >> 1);
    // Hold low period while a host slave stalls the command phase
    assign stall = anyOwn && cmd && !stallN && lowPhase;

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            divCnt_q <= 4'h0;
            expBusClk <= 1'b0;
        end else begin
            if (!stall) begin
                divCnt_q <= (divCnt_q >= divRatio - 4'h1) ? 4'h0 : divCnt_q + 4'h1;
            end
            expBusClk <= !lowPhase;
        end
    end

    //--------------------------------------------------------------
    // Slot enable decode
    //--------------------------------------------------------------
    for (i = 0; i < `HXB_SLOTS; i++) begin : g_slot
        always_ff @(posedge core_clk) begin
            if (!resetn) begin
                slotEnableN[i] <= 1'b1;
            end else begin
                slotEnableN[i] <= gSlotN || addrHi[7:4] != 4'(i + 1)
                    || addrHi[1:0] != `HXB_SLOT_LOW_MASK;
            end
        end
    end

endmodule // hxb_bridge

/* hxb_checker.sv */
// Port assertions for the bridge control block.
// Assumes binding onto hxb_bridge; one clock, sync active-low reset.
`timescale 1ns/100ps

module hxb_checker (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Watched ports
    input wire logic peripheralHoldRequest,
    input wire logic hostHoldRequest,
    input wire logic hostHoldGrant,
    input wire logic hostEarlyReadyOutN,
    input wire logic hostReadyOutN,
    input wire logic hostPipelineAddrOkN,
    input wire logic expCycleStart,
    input wire logic expCycleMem,
    input wire logic hostByteLanesOe,
    input wire logic hostUpperByteFlagOe,
    input wire logic hostDataControlSelOe,
    input wire logic hostDataControlSelOut,
    input wire logic hostMemIoSelOe,
    input wire logic hostMemIoSelOut,
    input wire logic globalSlotEnableN,
    input wire logic [5:0] slotEnableN
);
    // ----------------------------------------
    // Recovery gap tracking
    // ----------------------------------------
    logic [7:0] gapQ;
    logic ioQ;

    // Cycles since the last forwarded ready, and whether it was I/O
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            gapQ <= 8'hFF;
            ioQ <= 1'b0;
        end else if (!hostReadyOutN) begin
            gapQ <= 8'h00;
            ioQ <= !expCycleMem;
        end else if (gapQ != 8'hFF) begin
            gapQ <= gapQ + 8'h01;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    a_io_recovery: assert property (expCycleStart && !expCycleMem && ioQ |-> gapQ >= 8'h14)
        else $error("I/O cycle started inside recovery time");
    a_next_addr: assert property (expCycleStart |=> !hostPipelineAddrOkN && !expCycleStart)
        else $error("next address not pulsed after start");
    a_ready_pulse: assert property (!hostReadyOutN |=> hostReadyOutN)
        else $error("ready output longer than one cycle");
    a_early_ready: assert property (!hostEarlyReadyOutN |=> !hostReadyOutN)
        else $error("early ready not followed by ready");
    a_hold_follow: assert property ($rose(peripheralHoldRequest) |-> ##[1:4] hostHoldRequest)
        else $error("hold request not passed on");
    a_lanes_input: assert property ((!hostHoldGrant)[*3] |-> !hostByteLanesOe && !hostUpperByteFlagOe)
        else $error("lanes driven while host owns the bus");
    a_dc_high: assert property (hostDataControlSelOe |-> hostDataControlSelOut)
        else $error("data/control not driven high");
    a_memio_high: assert property (hostMemIoSelOe |-> hostMemIoSelOut)
        else $error("memory/io not driven high");
    a_slot_off: assert property (globalSlotEnableN[*4] |-> &slotEnableN)
        else $error("slot enabled while global enable high");
    a_slot_single: assert property ($onehot0(~slotEnableN))
        else $error("more than one slot enabled");
endmodule // hxb_checker

/* hxb_host_slave.sv */
// Host side partner: local slave claims, host ready and hold grant.
// Assumes the bench picks the claim mode before each strobe.
`timescale 1ns/100ps

module hxb_host_slave (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Host bus view
    input wire logic [1:0] hostAddressStrobes,
    input wire logic [1:0] claimMode,
    input wire logic hostHoldRequest,
    output logic hostLocalMemoryClaimN,
    output logic hostLocalIoClaimN,
    output logic hostReadyInN,
    output logic hostHoldGrant
);
    logic [3:0] cntQ;
    logic [1:0] grantQ;

    // Claimed cycle lasts until the counter wraps
    always_ff @(posedge core_clk) begin
        if (!resetn) cntQ <= 4'h0;
        else if (cntQ != 4'h0) cntQ <= cntQ + 4'h1;
        else if (|hostAddressStrobes && claimMode != 2'h0) cntQ <= 4'h1;
    end

    // Grant comes two cycles after the hold request
    always_ff @(posedge core_clk) begin
        if (!resetn) grantQ <= 2'h0;
        else grantQ <= {grantQ[0], hostHoldRequest};
    end

    // Claims, ready and grant pins
    assign hostLocalMemoryClaimN = !(cntQ != 4'h0 && claimMode == 2'h1);
    assign hostLocalIoClaimN = !(cntQ != 4'h0 && claimMode == 2'h2);
    assign hostReadyInN = !(cntQ == 4'hF);
    assign hostHoldGrant = grantQ[1];
endmodule // hxb_host_slave

/* testbench.sv */
// Self-checking bench for the bridge control block.
// Assumes hxb_bridge, hxb_host_slave and hxb_checker are compiled first.
`timescale 1ns/100ps

module testbench;
    typedef struct {logic [2:0] sel; logic [7:0] per;} hxb_clk_row_t;
    logic core_clk = 1'b0, resetn = 1'b0;
    logic [1:0] hostAddressStrobes = 2'h0, claimMode = 2'h0;
    logic [3:0] hostByteLanesNIn = 4'hF, expByteLanesN = 4'hF;
    logic hostUpperByteFlagNIn = 1'b1, hostDataControlSelIn = 1'b1, hostWriteReadSelIn = 1'b0;
    logic hostMemIoSelIn = 1'b0, hostClockStallN = 1'b1, hostLockInN = 1'b1;
    logic peripheralHoldRequest = 1'b0, peripheralReady = 1'b0, peripheralTarget = 1'b0;
    logic expReady = 1'b1, chanReady = 1'b1, noWaitN = 1'b1, expMasterCycle = 1'b0;
    logic dmaCycle = 1'b0, dmaIoToMem = 1'b0, expCommand = 1'b0, expMasterWrite = 1'b0;
    logic expMasterMem = 1'b0, expUpperByteN = 1'b1, globalSlotEnableN = 1'b1;
    logic [2:0] clkRatioSel = 3'h0;
    logic [7:0] slotAddrHigh = 8'h00, per, exp;
    logic [3:0] hostByteLanesNOut, expCycleByteLanesN;
    logic [5:0] slotEnableN;
    logic hostByteLanesOe, hostUpperByteFlagNOut, hostUpperByteFlagOe, hostDataControlSelOut;
    logic hostDataControlSelOe, hostWriteReadSelOut, hostWriteReadSelOe, hostMemIoSelOut;
    logic hostMemIoSelOe, hostReadyOutN, hostEarlyReadyOutN, hostPipelineAddrOkN;
    logic hostSnoopStrobeN, hostHoldRequest, expCycleStart, expCycleWrite, expCycleMem;
    logic expCycleUpperByteN, expCycleIntAck, expCycleShutdown, expLockN, expBusClk;
    logic hostCycleStart, hostTargetMem, hostTargetIo, hostReadyInN, hostLocalMemoryClaimN;
    logic hostLocalIoClaimN, hostHoldGrant, lk, seen, clkPrev = 1'b0;
    int err_count = 0, n_checks = 0, cyc = 0, lastRise = 0, readyCyc = 0, i, a;
    hxb_clk_row_t rows [6] = '{'{3'h0, 8'h03}, '{3'h1, 8'h04}, '{3'h2, 8'h05},
        '{3'h3, 8'h06}, '{3'h4, 8'h08}, '{3'h7, 8'h08}};

    hxb_bridge uut (.*);
    hxb_host_slave u_slave (.*);

    // -------------------------------
    // Clock, cycle count, divider period
    // -------------------------------
    initial forever #25 core_clk = !core_clk;
    always @(posedge core_clk) cyc <= cyc + 1;
    always @(negedge core_clk) begin
        clkPrev <= expBusClk;
        if (expBusClk === 1'b1 && clkPrev === 1'b0) begin
            per <= 8'(cyc - lastRise);
            lastRise <= cyc;
        end
    end

    task automatic check(input logic [7:0] got, input logic [7:0] want);
        n_checks++;
        if (got !== want) begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, got, want);
        end
    endtask

    task automatic waitc(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // Forwarded host cycle with type bits {mem/io, data/control, write/read}
    task automatic fwd(input logic [2:0] typ, output int gap);
        {hostMemIoSelIn, hostDataControlSelIn, hostWriteReadSelIn} <= typ;
        {hostUpperByteFlagNIn, hostByteLanesNIn} <= {typ[0], 1'b0, typ};
        hostAddressStrobes <= 2'h1;
        waitc(1);
        hostAddressStrobes <= 2'h0;
        lk = 1'b0;
        for (i = 0; i < 80 && expCycleStart !== 1'b1; i++) @(negedge core_clk);
        gap = cyc - readyCyc;
        check(i < 80, 1);
        check({expCycleMem, expCycleWrite}, {typ[2], typ[0]});
        check({expCycleIntAck, expCycleShutdown}, {typ == 3'h0, typ == 3'h5});
        check({expCycleUpperByteN, expCycleByteLanesN}, {typ[0], 1'b0, typ});
        @(negedge core_clk);
        check(hostPipelineAddrOkN, 0);
        for (i = 0; i < 40 && hostEarlyReadyOutN !== 1'b0; i++) begin
            lk |= !expLockN;
            @(negedge core_clk);
        end
        @(negedge core_clk);
        readyCyc = cyc;
        check(hostReadyOutN, 0);
        waitc(1);
    endtask

    initial begin
        #1000000;
        err_count++;
        close_out();
    end

    // -------------------------------
    // Main sequence
    // -------------------------------
    initial begin
        waitc(10);
        resetn <= 1'b1;
        @(negedge core_clk);
        check({hostReadyOutN, hostEarlyReadyOutN, expBusClk, hostHoldRequest}, 4'hC);
        check(slotEnableN, 8'h3F);
        // Divider ratios from the table
        foreach (rows[r]) begin
            waitc(1);
            clkRatioSel <= rows[r].sel;
            waitc(40);
            @(negedge core_clk);
            check(per, rows[r].per);
        end
        // Back-to-back I/O cycles, the second locked and an acknowledge type
        waitc(1);
        fwd(3'h3, a);
        hostLockInN <= 1'b0;
        fwd(3'h0, a);
        check(a, 21);
        check(lk, 1);
        hostLockInN <= 1'b1;
        fwd(3'h5, a);
        // Claimed memory then I/O cycles: nothing forwarded
        for (int m = 1; m < 3; m++) begin
            waitc(1);
            claimMode <= 2'(m);
            hostMemIoSelIn <= (m == 1);
            hostAddressStrobes <= 2'h3;
            waitc(1);
            hostAddressStrobes <= 2'h0;
            seen = 1'b0;
            repeat (30) begin
                @(negedge core_clk);
                seen |= expCycleStart;
            end
            check(seen, 0);
        end
        waitc(1);
        claimMode <= 2'h0;
        // Expansion master owns the host bus
        peripheralHoldRequest <= 1'b1;
        {expMasterCycle, expMasterWrite, expMasterMem, expUpperByteN} <= 4'hE;
        expByteLanesN <= 4'h5;
        waitc(12);
        @(negedge core_clk);
        check(hostHoldRequest, 1);
        check({hostByteLanesOe, hostByteLanesNOut}, 8'h15);
        check({hostUpperByteFlagOe, hostUpperByteFlagNOut, hostMemIoSelOe}, 3'h4);
        check({hostWriteReadSelOe, hostWriteReadSelOut}, 2'h3);
        check({hostDataControlSelOe, hostDataControlSelOut}, 2'h3);
        waitc(1);
        expCommand <= 1'b1;
        seen = 1'b0;
        lk = 1'b0;
        repeat (8) begin
            @(negedge core_clk);
            seen |= hostCycleStart;
            lk |= !hostSnoopStrobeN;
        end
        check({seen, lk}, 2'h3);
        // Host memory slave claims while the master owns the bus
        waitc(1);
        claimMode <= 2'h1;
        hostAddressStrobes <= 2'h1;
        waitc(1);
        hostAddressStrobes <= 2'h0;
        waitc(5);
        @(negedge core_clk);
        check({hostTargetMem, hostTargetIo}, 2'h2);
        waitc(1);
        claimMode <= 2'h0;
        hostClockStallN <= 1'b0;
        waitc(12);
        seen = 1'b0;
        repeat (30) begin
            @(negedge core_clk);
            seen |= expBusClk;
        end
        check(seen, 0);
        waitc(1);
        {hostClockStallN, expCommand, expMasterCycle, dmaCycle} <= 4'h9;
        waitc(8);
        @(negedge core_clk);
        check({hostMemIoSelOe, hostMemIoSelOut, hostWriteReadSelOe}, 3'h6);
        waitc(1);
        {peripheralHoldRequest, dmaCycle} <= 2'h0;
        // Every slot address, then global enable high
        globalSlotEnableN <= 1'b0;
        for (int s = 0; s < 256; s++) begin
            slotAddrHigh <= 8'(s);
            waitc(4);
            @(negedge core_clk);
            exp = 8'h3F;
            if (s[1:0] == 2'h0 && s[7:4] >= 1 && s[7:4] <= 6) exp[s[7:4] - 1] = 1'b0;
            check(slotEnableN, exp);
            waitc(1);
        end
        slotAddrHigh <= 8'h10;
        globalSlotEnableN <= 1'b1;
        waitc(5);
        @(negedge core_clk);
        check(slotEnableN, 8'h3F);
        waitc(1);
        // Second reset in mid-run
        peripheralHoldRequest <= 1'b1;
        waitc(6);
        resetn <= 1'b0;
        waitc(2);
        @(negedge core_clk);
        check({hostHoldRequest, expBusClk, hostReadyOutN}, 3'h1);
        // Release again: hold request returns after the synchronisers
        waitc(1);
        resetn <= 1'b1;
        @(negedge core_clk);
        check({hostHoldRequest, expBusClk}, 2'h0);
        waitc(4);
        @(negedge core_clk);
        check(hostHoldRequest, 1);
        close_out();
    end
endmodule // testbench

bind hxb_bridge hxb_checker u_chk (.*);
